/* File: hw/bus_match_breakpoint_timer.sv */
// breakpoint, trace match, strobe watchdog and elapsed timer behind an AHB-Lite slave
//
// Operation
// R1: halt-enable register enables each break match alone; OR of both halts on either
// R2: run-unconditionally setting disables both break matches; only host abort stops
// R3: AND mode halts only when both break matches hit together; here AND acts only with both halt enables set
// R4: execution match on queue byte whose address equals or fits masked pattern
// R5: non-execution match needs all present fields within one register
// R6: writing the combined selector loads both break registers identically
// R7: two trace registers, start and stop, never use execution matching
// R8: software must not mix address range with data or segment in trace
// R9: watchdog on host-mapped access forces user strobes inactive on expiry
// R10: elapsed timer advances every 500 ns only while emulation runs
// R11: timer begins counting at first T3 state after start
// R12: low half wraps freely; full count stops at its maximum; here the high half holds at FFFF while the low half keeps wrapping
// R13: timer cleared on start-from, program counter change, trace enable change
// R14: timer read as separate low and high 16-bit halves
// R15: data, status, segment sampled at data time; address, status at address time; here status is sampled only at address time (ale)
// R16: data matching compares only the low 8 bits
// R17: one register holds address spans of at most 1K bytes
// R18: start-trace match begins capture, stop-trace match ends it
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module bus_match_breakpoint_timer (
   input wire logic mclk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ale,
   input wire logic dataValid,
   input wire logic [2:0] busStatus,
   input wire logic [19:0] addrBus,
   input wire logic [7:0] adBus,
   input wire logic [1:0] segUsed,
   input wire logic t3State,
   input wire logic queueTake,
   input wire logic [19:0] queueAddr,
   input wire logic hostAccess,
   input wire logic cpuRdN,
   input wire logic cpuWrN,
   output logic userRdN,
   output logic userWrN,
   output logic emuRunning,
   output logic traceCapture
);
   import bus_match_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] hrdata;
      logic ready;
      logic resp;
      logic [3:0][3:0][31:0] cfg;
      logic [3:0] haltMode;
      logic traceOn;
      logic [15:0] wdSetting;
      logic running;
      logic counting;
      logic haltA;
      logic haltB;
      logic capture;
      logic [15:0] timerLo;
      logic [15:0] timerHi;
      logic [9:0] tickAcc;
      logic [15:0] wdCount;
      logic wdActive;
      logic inhibit;
      logic prevHost;
      logic userRdN;
      logic userWrN;
   } state_t;

   state_t st;
   state_t next_st;

   logic [3:0] hit;
   logic accept;
   logic startCmd;
   logic startFrom;
   logic abortCmd;
   logic clearTimer;
   logic srcA;
   logic srcB;
   logic haltNow;
   logic tick;
   logic [9:0] accSum;

   function automatic logic inUnit(input logic [7:0] a, input logic [7:0] base);
      inUnit = (a & REGION_MASK) == base;
   endfunction

   function automatic logic [31:0] readReg(input state_t s, input logic [7:0] a);
      readReg = WORD_RESET;
      if (inUnit(a, MATCH_BASE)) begin
         readReg = s.cfg[a[5:4]][a[3:2]];
      end else if ((a & UNIT_MASK) == BOTH_BASE) begin
         readReg = s.cfg[U_A][a[3:2]];
      end else begin
         case (a)
            OFF_CMD: readReg = {26'h0, s.inhibit, s.capture, s.haltB, s.haltA, s.counting,
               s.running};
            OFF_HALT: readReg = {28'h0, s.haltMode};
            OFF_TRACE: readReg = {31'h0, s.traceOn};
            OFF_WDOG: readReg = {16'h0, s.wdSetting};
            OFF_TLO: readReg = {16'h0, s.timerLo}; // R14
            OFF_THI: readReg = {16'h0, s.timerHi}; // R14
            default: readReg = WORD_RESET;
         endcase
      end
   endfunction

   // ****************************************
   // match units
   // ****************************************
   match_if mi[4] ();

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_unit
         assign mi[g].cfg = st.cfg[g];
         // trace units never take the execution form
         assign mi[g].allowExec = (g == U_A) || (g == U_B); // R7
         assign mi[g].ale = ale;
         assign mi[g].dataValid = dataValid;
         assign mi[g].busStatus = busStatus;
         assign mi[g].addr = addrBus;
         assign mi[g].ad = adBus;
         assign mi[g].seg = segUsed;
         assign mi[g].qTake = queueTake;
         assign mi[g].qAddr = queueAddr;
         assign hit[g] = mi[g].match;
         bus_match_unit u_unit (
            .mclk(mclk),
            .srst(srst),
            .u(mi[g])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      startCmd = 1'b0;
      startFrom = 1'b0;
      abortCmd = 1'b0;
      clearTimer = 1'b0;
      // bus slave: zero wait states, read data registered at the address phase
      accept = hsel && htrans[1] && hready;
      next_st.wrPend = accept && hwrite;
      next_st.ready = 1'b1;
      next_st.resp = 1'b0;
      if (accept) begin
         next_st.wrAddr = haddr[7:0];
      end
      if (accept && !hwrite) begin
         next_st.hrdata = readReg(st, haddr[7:0]);
      end
      if (st.wrPend) begin
         if (inUnit(st.wrAddr, MATCH_BASE)) begin
            next_st.cfg[st.wrAddr[5:4]][st.wrAddr[3:2]] = hwdata;
         end else if ((st.wrAddr & UNIT_MASK) == BOTH_BASE) begin
            next_st.cfg[U_A][st.wrAddr[3:2]] = hwdata; // R6
            next_st.cfg[U_B][st.wrAddr[3:2]] = hwdata; // R6
         end else begin
            case (st.wrAddr)
               OFF_CMD: begin
                  startCmd = hwdata[CMD_START] | hwdata[CMD_START_FROM];
                  startFrom = hwdata[CMD_START_FROM];
                  abortCmd = hwdata[CMD_ABORT];
                  clearTimer = hwdata[CMD_START_FROM] | hwdata[CMD_CLEAR]; // R13
               end
               OFF_HALT: next_st.haltMode = hwdata[3:0];
               OFF_TRACE: begin
                  next_st.traceOn = hwdata[0];
                  clearTimer = hwdata[0] != st.traceOn; // R13
               end
               OFF_WDOG: next_st.wdSetting = hwdata[15:0];
               default: begin
               end
            endcase
         end
      end

      // halt sources
      srcA = st.haltMode[HE_A] && !st.haltMode[HE_FOREVER] && hit[U_A]; // R1 R2
      srcB = st.haltMode[HE_B] && !st.haltMode[HE_FOREVER] && hit[U_B]; // R1 R2
      if (st.haltMode[HE_AND] && st.haltMode[HE_A] && st.haltMode[HE_B]) begin
         haltNow = srcA && srcB; // R3
      end else begin
         haltNow = srcA || srcB; // R1
      end

      // emulation run state
      if (st.running) begin
         if (haltNow) begin
            next_st.running = 1'b0;
            next_st.counting = 1'b0;
            next_st.haltA = srcA;
            next_st.haltB = srcB;
         end else if (abortCmd) begin
            next_st.running = 1'b0; // R2
            next_st.counting = 1'b0;
         end else if (t3State) begin
            next_st.counting = 1'b1; // R11
         end
      end else if (startCmd) begin
         next_st.running = 1'b1;
         next_st.counting = 1'b0; // R11
         next_st.haltA = 1'b0;
         next_st.haltB = 1'b0;
      end

      // 2 MHz tick by phase accumulation keeps the average period exact
      accSum = st.tickAcc + CLK_NS;
      tick = accSum >= TICK_NS; // R10
      if (tick) begin
         next_st.tickAcc = accSum - TICK_NS;
      end else begin
         next_st.tickAcc = accSum;
      end

      // elapsed timer
      if (clearTimer) begin
         next_st.timerLo = 16'h0000; // R13
         next_st.timerHi = 16'h0000; // R13
         next_st.tickAcc = 10'h000;
      end else if (st.running && st.counting && tick) begin // R10
         next_st.timerLo = st.timerLo + 16'h0001; // R12
         // the high half holds at its maximum while the low half keeps wrapping
         if (st.timerLo == HALF_MAX && st.timerHi != HALF_MAX) begin
            next_st.timerHi = st.timerHi + 16'h0001; // R12
         end
      end

      // trace capture: a start hit wins over a stop hit in the same cycle
      if (!st.traceOn) begin
         next_st.capture = 1'b0;
      end else if (hit[U_START]) begin
         next_st.capture = 1'b1; // R18
      end else if (hit[U_STOP]) begin
         next_st.capture = 1'b0; // R18
      end

      // strobe watchdog for host- or disk-mapped accesses
      next_st.prevHost = hostAccess;
      if (!hostAccess) begin
         next_st.wdActive = 1'b0;
         next_st.inhibit = 1'b0;
      end else if (!st.prevHost) begin
         next_st.wdActive = 1'b1; // R9
         next_st.wdCount = st.wdSetting;
         next_st.inhibit = 1'b0;
      end else if (st.wdActive) begin
         if (st.wdCount == 16'h0000) begin
            next_st.wdActive = 1'b0;
            next_st.inhibit = 1'b1; // R9
         end else begin
            next_st.wdCount = st.wdCount - 16'h0001;
         end
      end
      // strobes lag the processor by one clock so they leave from a flop
      next_st.userRdN = cpuRdN | next_st.inhibit; // R9
      next_st.userWrN = cpuWrN | next_st.inhibit; // R9
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '0;
         st.ready <= 1'b1;
         st.userRdN <= 1'b1;
         st.userWrN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata = st.hrdata;
   assign hreadyout = st.ready;
   assign hresp = st.resp;
   assign userRdN = st.userRdN;
   assign userWrN = st.userWrN;
   assign emuRunning = st.running;
   assign traceCapture = st.capture;
endmodule

/* File: hw/bus_match_pkg.sv */
// constants, register map and field layouts shared by the bus match logic
package bus_match_pkg;
   // ****************************************
   // register map (byte addresses, low 8 bits of haddr)
   // ****************************************
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_HALT = 8'h04;
   localparam logic [7:0] OFF_TRACE = 8'h08;
   localparam logic [7:0] OFF_WDOG = 8'h0C;
   localparam logic [7:0] OFF_TLO = 8'h10;
   localparam logic [7:0] OFF_THI = 8'h14;
   localparam logic [7:0] MATCH_BASE = 8'h40;
   localparam logic [7:0] BOTH_BASE = 8'h80;
   localparam logic [7:0] REGION_MASK = 8'hC0;
   localparam logic [7:0] UNIT_MASK = 8'hF0;
   localparam logic [31:0] WORD_RESET = 32'h0;
   // ****************************************
   // field positions
   // ****************************************
   localparam int CMD_START = 0;
   localparam int CMD_START_FROM = 1;
   localparam int CMD_ABORT = 2;
   localparam int CMD_CLEAR = 3;
   localparam int HE_A = 0;
   localparam int HE_B = 1;
   localparam int HE_AND = 2;
   localparam int HE_FOREVER = 3;
   localparam int U_A = 0;
   localparam int U_B = 1;
   localparam int U_START = 2;
   localparam int U_STOP = 3;
   localparam int W_PATTERN = 0;
   localparam int W_CARE = 1;
   localparam int W_CTRL = 2;
   localparam int W_DATA = 3;
   localparam int C_USE_ADDR = 0;
   localparam int C_RANGE = 1;
   localparam int C_USE_STAT = 2;
   localparam int C_USE_DATA = 3;
   localparam int C_USE_SEG = 4;
   localparam int C_EXEC = 5;
   localparam int C_STAT_LSB = 6;
   localparam int C_SEG_LSB = 13;
   localparam int C_SPAN_LSB = 16;
   localparam int D_LO_LSB = 0;
   localparam int D_HI_LSB = 8;
   localparam int D_CARE_LSB = 16;
   // ****************************************
   // bus status codes and timing
   // ****************************************
   localparam logic [2:0] BS_ACK = 3'h0;
   localparam logic [2:0] BS_IORD = 3'h1;
   localparam logic [2:0] BS_IOWR = 3'h2;
   localparam logic [2:0] BS_HALT = 3'h3;
   localparam logic [2:0] BS_FETCH = 3'h4;
   localparam logic [2:0] BS_MRD = 3'h5;
   localparam logic [2:0] BS_MWR = 3'h6;
   localparam logic [9:0] CLK_NS = 10'h028;
   localparam logic [9:0] TICK_NS = 10'h1F4;
   localparam logic [15:0] HALF_MAX = 16'hFFFF;
   typedef logic [3:0][31:0] cfg_words_t;
endpackage

/* File: hw/match_if.sv */
// carrier between the control block and one match unit
`timescale 1ns/1ps
interface match_if;
   import bus_match_pkg::*;
   cfg_words_t cfg;
   logic allowExec;
   logic ale;
   logic dataValid;
   logic [2:0] busStatus;
   logic [19:0] addr;
   logic [7:0] ad;
   logic [1:0] seg;
   logic qTake;
   logic [19:0] qAddr;
   logic match;
   modport ctl(output cfg, allowExec, ale, dataValid, busStatus, addr, ad, seg, qTake, qAddr,
      input match);
   modport unit(input cfg, allowExec, ale, dataValid, busStatus, addr, ad, seg, qTake, qAddr,
      output match);
endinterface

/* File: hw/bus_match_unit.sv */
// one match register comparator: execution or address/status/data/segment match
`timescale 1ns/1ps
module bus_match_unit (
   input wire logic mclk,
   input wire logic srst,
   match_if.unit u
);
   import bus_match_pkg::*;

   typedef struct packed {
      logic aHit;
      logic sHit;
      logic match;
   } unit_t;

   unit_t st;
   unit_t next_st;

   function automatic logic addrOk(input cfg_words_t c, input logic [19:0] a);
      logic [19:0] diff;
      diff = a - c[W_PATTERN][19:0];
      // range form spans at most 1K bytes above its base
      if (c[W_CTRL][C_RANGE]) begin // R17
         addrOk = (a >= c[W_PATTERN][19:0]) && (diff <= {10'h000, c[W_CTRL][C_SPAN_LSB +: 10]});
      end else begin
         addrOk = ((a ^ c[W_PATTERN][19:0]) & c[W_CARE][19:0]) == 20'h00000;
      end
   endfunction

   function automatic logic [6:0] statusSet(input logic [2:0] bs);
      case (bs)
         BS_MRD: statusSet = 7'h01;
         BS_MWR: statusSet = 7'h02;
         BS_IORD: statusSet = 7'h04;
         BS_IOWR: statusSet = 7'h08;
         BS_FETCH: statusSet = 7'h10;
         BS_HALT: statusSet = 7'h20;
         BS_ACK: statusSet = 7'h40;
         default: statusSet = 7'h00;
      endcase
   endfunction

   logic [31:0] ctrl;
   logic [7:0] dMasked;
   logic dHit;
   logic gHit;
   logic anyField;

   always_comb begin
      next_st = st;
      ctrl = u.cfg[W_CTRL];
      dMasked = u.ad & u.cfg[W_DATA][D_CARE_LSB +: 8];
      // only the low byte of a data value is compared
      dHit = !ctrl[C_USE_DATA] || ((dMasked >= u.cfg[W_DATA][D_LO_LSB +: 8]) // R16
         && (dMasked <= u.cfg[W_DATA][D_HI_LSB +: 8]));
      gHit = !ctrl[C_USE_SEG] || (u.seg == ctrl[C_SEG_LSB +: 2]);
      anyField = ctrl[C_USE_ADDR] | ctrl[C_USE_STAT] | ctrl[C_USE_DATA] | ctrl[C_USE_SEG];
      // address-time fields are caught at the address strobe
      if (u.ale) begin // R15
         next_st.aHit = !ctrl[C_USE_ADDR] || addrOk(u.cfg, u.addr);
         next_st.sHit = !ctrl[C_USE_STAT] || |(ctrl[C_STAT_LSB +: 7] & statusSet(u.busStatus));
      end
      if (ctrl[C_EXEC] && u.allowExec) begin
         next_st.match = u.qTake && addrOk(u.cfg, u.qAddr); // R4
      end else begin
         // every field present must hold in the same bus cycle
         next_st.match = u.dataValid && anyField && st.aHit && st.sHit && dHit && gHit; // R5 R15
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign u.match = st.match;
endmodule

/* File: tb/bus_match_breakpoint_timer_monitor.sv */
// concurrent checks on the ports of the bus match block
`timescale 1ns/1ps
module bus_match_breakpoint_timer_monitor (
   input wire logic mclk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic dataValid,
   input wire logic queueTake,
   input wire logic hostAccess,
   input wire logic cpuRdN,
   input wire logic cpuWrN,
   input wire logic userRdN,
   input wire logic userWrN,
   input wire logic emuRunning,
   input wire logic traceCapture
);
   logic wrTake;
   logic rdTake;
   logic [3:0] evHist;
   assign wrTake = hsel && htrans[1] && hready && hwrite;
   assign rdTake = hsel && htrans[1] && hready && !hwrite;
   // bus events of the last four cycles; only these may end a run or a capture
   always_ff @(posedge mclk) begin
      evHist <= {evHist[2:0], dataValid || queueTake || wrTake};
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   property p_bus_ok; hreadyout && !hresp; endproperty
   a_bus_ok: assert property (p_bus_ok)
      else $error("slave not ready or not okay");
   property p_rd_hold; $changed(hrdata) |-> $past(rdTake); endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");
   property p_rd_follow; cpuRdN |=> userRdN; endproperty
   a_rd_follow: assert property (p_rd_follow)
      else $error("user read strobe active without processor strobe");
   property p_wr_follow; cpuWrN |=> userWrN; endproperty
   a_wr_follow: assert property (p_wr_follow)
      else $error("user write strobe active without processor strobe");
   property p_rd_release; (!hostAccess && !cpuRdN) [*3] |=> !userRdN; endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("user read strobe held off outside host access");
   property p_start; $rose(emuRunning) |-> $past(wrTake, 2) || $past(wrTake, 3); endproperty
   a_start: assert property (p_start)
      else $error("run began without a command write");
   property p_halt; $fell(emuRunning) |-> (evHist != 4'h0); endproperty
   a_halt: assert property (p_halt)
      else $error("run ended without a bus event or abort");
   property p_cap_on;
      $rose(traceCapture) |-> $past(dataValid, 1) || $past(dataValid, 2) || $past(dataValid, 3);
   endproperty
   a_cap_on: assert property (p_cap_on)
      else $error("capture began without a data phase");
   property p_cap_off; $fell(traceCapture) |-> (evHist != 4'h0); endproperty
   a_cap_off: assert property (p_cap_off)
      else $error("capture ended without cause");
   c_halt: cover property ($fell(emuRunning));
   c_cap: cover property ($rose(traceCapture));
   c_inhibit: cover property (hostAccess && !cpuRdN && userRdN);
endmodule

bind bus_match_breakpoint_timer bus_match_breakpoint_timer_monitor mon_i (
   .mclk(mclk), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dataValid(dataValid),
   .queueTake(queueTake), .hostAccess(hostAccess), .cpuRdN(cpuRdN), .cpuWrN(cpuWrN),
   .userRdN(userRdN), .userWrN(userWrN), .emuRunning(emuRunning), .traceCapture(traceCapture)
);

/* File: tb/cpu_bus_model.sv */
// behavioural processor bus that drives the match block pins
`timescale 1ns/1ps
module cpu_bus_model (
   input wire logic mclk,
   output logic ale,
   output logic dataValid,
   output logic [2:0] busStatus,
   output logic [19:0] addrBus,
   output logic [7:0] adBus,
   output logic [1:0] segUsed,
   output logic t3State,
   output logic queueTake,
   output logic [19:0] queueAddr,
   output logic hostAccess,
   output logic cpuRdN,
   output logic cpuWrN
);
   initial begin
      {ale, dataValid, t3State, queueTake, hostAccess} = 5'h00;
      {cpuRdN, cpuWrN} = 2'h3;
      busStatus = 3'h7;
      addrBus = 20'h00000;
      adBus = 8'h00;
      segUsed = 2'h0;
      queueAddr = 20'h00000;
   end
   // ****************************************
   // bus cycles; gap adds wait cycles between address and data time
   // ****************************************
   task automatic cycle(input logic [2:0] st, input logic [7:0] d, input int gap);
      @(posedge mclk);
      ale <= 1'b1;
      busStatus <= st;
      addrBus <= 20'h03000;
      @(posedge mclk);
      ale <= 1'b0;
      repeat (gap) @(posedge mclk);
      dataValid <= 1'b1;
      adBus <= d;
      segUsed <= 2'h3;
      @(posedge mclk);
      dataValid <= 1'b0;
      busStatus <= 3'h7;
      // released lines must not keep their last value
      addrBus <= ~addrBus;
      adBus <= ~d;
   endtask
   task automatic take(input logic [19:0] a);
      @(posedge mclk);
      queueTake <= 1'b1;
      queueAddr <= a;
      @(posedge mclk);
      queueTake <= 1'b0;
      queueAddr <= ~a;
   endtask
   task automatic t3();
      @(posedge mclk);
      t3State <= 1'b1;
      @(posedge mclk);
      t3State <= 1'b0;
   endtask
   task automatic host(input logic acc, input logic rdN, input logic wrN);
      @(posedge mclk);
      hostAccess <= acc;
      cpuRdN <= rdN;
      cpuWrN <= wrN;
   endtask
endmodule

/* File: tb/bus_match_breakpoint_timer_bench.sv */
// self-checking bench for the bus match block
`timescale 1ns/1ps
module bus_match_breakpoint_timer_bench;
   import bus_match_pkg::*;
   typedef struct {logic [3:0] he; logic [2:0] st; logic [7:0] d; logic run;} step_t;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, v;
   logic hreadyout, hresp, ale, dataValid, t3State, queueTake, hostAccess, cpuRdN, cpuWrN;
   logic userRdN, userWrN, emuRunning, traceCapture;
   logic [2:0] busStatus;
   logic [19:0] addrBus, queueAddr;
   logic [7:0] adBus;
   logic [1:0] segUsed;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   step_t steps[8] = '{'{4'h1, BS_MRD, 8'h00, 1'b1}, '{4'h1, BS_MWR, 8'h00, 1'b0},
      '{4'h9, BS_MWR, 8'h00, 1'b1}, '{4'h7, BS_MWR, 8'h00, 1'b1}, '{4'h7, BS_MRD, 8'h10, 1'b1},
      '{4'h7, BS_MWR, 8'h10, 1'b0}, '{4'h3, BS_MRD, 8'h10, 1'b0}, '{4'h2, BS_MWR, 8'h00, 1'b1}};
   bus_match_breakpoint_timer bus_match_breakpoint_timer_i (.mclk(mclk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ale(ale), .dataValid(dataValid), .busStatus(busStatus),
      .addrBus(addrBus), .adBus(adBus), .segUsed(segUsed), .t3State(t3State),
      .queueTake(queueTake), .queueAddr(queueAddr), .hostAccess(hostAccess), .cpuRdN(cpuRdN),
      .cpuWrN(cpuWrN), .userRdN(userRdN), .userWrN(userWrN), .emuRunning(emuRunning),
      .traceCapture(traceCapture));
   cpu_bus_model cpu_bus_model_i (.mclk(mclk), .ale(ale), .dataValid(dataValid),
      .busStatus(busStatus), .addrBus(addrBus), .adBus(adBus), .segUsed(segUsed),
      .t3State(t3State), .queueTake(queueTake), .queueAddr(queueAddr),
      .hostAccess(hostAccess), .cpuRdN(cpuRdN), .cpuWrN(cpuWrN));
   always #20 mclk = ~mclk;
   // a hang costs at most this many cycles; the full run needs under 3000
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      comparisons++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         mismatches++;
         $display("ERROR at %0t ns: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   task automatic bit_chk(input logic b, input logic e);
      chk({31'h0, b}, {31'h0, e}, {31'h0, e});
   endtask
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
      bus(a, 1'b0, 32'h0);
      chk(v, lo, hi);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      wait_cyc(1);
      bit_chk(hreadyout, 1'b1);
      rd(OFF_CMD, 32'h0, 32'h0);
      rd(OFF_HALT, 32'h0, 32'h0);
      $display("test reset done");
      wr(MATCH_BASE + 8'h08, 32'h00000084);
      wr(MATCH_BASE + 8'h1C, 32'h00FF1010);
      wr(MATCH_BASE + 8'h18, 32'h00000008);
      foreach (steps[i]) begin
         wr(OFF_HALT, {28'h0, steps[i].he});
         wr(OFF_CMD, 32'h1);
         cpu_bus_model_i.cycle(steps[i].st, steps[i].d, i % 3);
         wait_cyc(4);
         bit_chk(emuRunning, steps[i].run);
         wr(OFF_CMD, 32'h4);
      end
      $display("test halt table done");
      wr(BOTH_BASE, 32'h000ABCDE);
      rd(MATCH_BASE + 8'h10, 32'h000ABCDE, 32'h000ABCDE);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0, 32'h0);
      wr(OFF_WDOG, 32'h00010003);
      rd(OFF_WDOG, 32'h00000003, 32'h00000003);
      $display("test registers done");
      wr(MATCH_BASE, 32'h00012340);
      wr(MATCH_BASE + 8'h04, 32'h000FFFF0);
      wr(MATCH_BASE + 8'h08, 32'h00000020);
      wr(OFF_HALT, 32'h1);
      wr(OFF_CMD, 32'h1);
      cpu_bus_model_i.take(20'h22345);
      wait_cyc(4);
      bit_chk(emuRunning, 1'b1);
      cpu_bus_model_i.take(20'h1234B);
      wait_cyc(4);
      bit_chk(emuRunning, 1'b0);
      wr(MATCH_BASE + 8'h08, 32'h00100022);
      wr(OFF_CMD, 32'h1);
      cpu_bus_model_i.take(20'h12350);
      wait_cyc(4);
      bit_chk(emuRunning, 1'b0);
      $display("test execution match done");
      // status-only conditions keep address-time and data-time fields apart
      wr(MATCH_BASE + 8'h28, 32'h00000104);
      wr(MATCH_BASE + 8'h38, 32'h00000204);
      wr(OFF_HALT, 32'h0);
      wr(OFF_TRACE, 32'h1);
      wr(OFF_CMD, 32'h1);
      cpu_bus_model_i.cycle(BS_IORD, 8'h00, 0);
      wait_cyc(4);
      bit_chk(traceCapture, 1'b1);
      cpu_bus_model_i.cycle(BS_IOWR, 8'h00, 2);
      wait_cyc(4);
      bit_chk(traceCapture, 1'b0);
      wr(OFF_CMD, 32'h4);
      $display("test trace done");
      wr(OFF_CMD, 32'h2);
      wait_cyc(50);
      rd(OFF_TLO, 32'h0, 32'h0);
      cpu_bus_model_i.t3();
      wait_cyc(250);
      wr(OFF_CMD, 32'h4);
      rd(OFF_TLO, 32'h13, 32'h17);
      rd(OFF_THI, 32'h0, 32'h0);
      wr(OFF_CMD, 32'h8);
      rd(OFF_TLO, 32'h0, 32'h0);
      // count a few ticks again so the trace toggle below has something to clear
      wr(OFF_CMD, 32'h1);
      cpu_bus_model_i.t3();
      wait_cyc(40);
      wr(OFF_CMD, 32'h4);
      wr(OFF_TRACE, 32'h0);
      rd(OFF_TLO, 32'h0, 32'h0);
      $display("test timer done");
      cpu_bus_model_i.host(1'b1, 1'b0, 1'b0);
      wait_cyc(2);
      bit_chk(userRdN, 1'b0);
      bit_chk(userWrN, 1'b0);
      wait_cyc(6);
      bit_chk(userRdN, 1'b1);
      bit_chk(userWrN, 1'b1);
      cpu_bus_model_i.host(1'b0, 1'b0, 1'b0);
      wait_cyc(3);
      bit_chk(userRdN, 1'b0);
      bit_chk(userWrN, 1'b0);
      cpu_bus_model_i.host(1'b0, 1'b1, 1'b1);
      $display("test watchdog done");
      wr(OFF_CMD, 32'h1);
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      wait_cyc(1);
      bit_chk(emuRunning, 1'b0);
      rd(OFF_CMD, 32'h0, 32'h0);
      $display("test reset in run done");
      give_verdict();
   end
endmodule
